/* File: dv/tkr_props.sv */
// Concurrent checks on the wires that join the touch device and its bus host.
`timescale 1ns/1ps
`default_nettype none
module tkr_props (
  input wire logic                            CORE_CLK_I,
  input wire logic                            RST_I,
  input wire logic [tkr_pkg::KEY_VALUE_W-1:0] KEY_VALUE_O,
  input wire logic                            scl,
  input wire logic                            sda,
  input wire logic                            int_n,
  input wire logic                            dev_sda_o,
  input wire logic                            dev_sda_oe,
  input wire logic                            dev_int_o,
  input wire logic                            dev_int_oe
);
  // The phase counters saturate so that a long idle bus cannot wrap them.
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || scl) begin
      low_cnt <= 8'h00;
    end else if (low_cnt != 8'hFF) begin
      low_cnt <= low_cnt + 8'h01;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || !scl) begin
      high_cnt <= 8'h00;
    end else if (high_cnt != 8'hFF) begin
      high_cnt <= high_cnt + 8'h01;
    end
  end

  a_reset_state : assert property (
    $fell(RST_I) |-> KEY_VALUE_O == 16'h0000 && int_n) else $error("Wrong state after reset.");
  a_int_tracks_keys : assert property (
    int_n == (KEY_VALUE_O == 16'h0000)) else $error("Status line disagrees with keys.");
  a_high_bits_zero : assert property (
    KEY_VALUE_O[15:10] == 6'h00) else $error("Unused key bits set.");
  a_drive_low_only : assert property (
    !dev_sda_o && !dev_int_o && (int_n == !dev_int_oe)) else $error("Device drives a line high.");
  a_data_in_low : assert property (
    $changed(dev_sda_oe) |-> !scl && !$past(scl)) else $error("Device data moved, clock high.");
  a_start_by_host : assert property (
    $fell(sda) && scl && $past(scl) |-> !dev_sda_oe) else $error("Device made a start.");
  a_stop_then_idle : assert property (
    $rose(sda) && scl && $past(scl) |=> (scl && sda) [*8]) else $error("Bus not idle after stop.");
  a_scl_low_time : assert property (
    $rose(scl) |-> low_cnt >= 8'h34) else $error("Clock low phase too short.");
  a_scl_high_time : assert property (
    $fell(scl) |-> high_cnt >= 8'h18) else $error("Clock high phase too short.");

  c_touch : cover property ($fell(int_n));
  c_ack   : cover property ($rose(dev_sda_oe));
  c_stop  : cover property ($rose(sda) && scl);
endmodule
`default_nettype wire

/* File: dv/touch_key_status_reporter_tb.sv */
// Self-checking bench: touch device and bus host joined by one interface.
`timescale 1ns/1ps
`default_nettype none
module touch_key_status_reporter_tb;
  import tkr_pkg::*;
  // Short counts keep the run near seventy thousand cycles.
  localparam int         LONG_P  = 8000;
  localparam int         STBY_P  = 800;
  localparam int         RESP_S  = 40;
  localparam int         RESP_N  = 12;
  localparam int         DRIFT_P = 50;
  localparam logic [7:0] BASE    = 8'h40;
  localparam logic [7:0] TOUCH   = 8'h80;
  logic                        CORE_CLK_I;
  logic                        RST_I = 1'b1;
  logic                        READ_REQ_I = 1'b0;
  logic [NUM_KEYS*SENSE_W-1:0] KEY_SENSE_I;
  logic [KEY_VALUE_W-1:0]      dev_value;
  logic [KEY_VALUE_W-1:0]      host_value;
  logic                        normal_mode;
  logic                        read_done;
  logic                        read_busy;
  logic                        read_nack;
  logic                        touched;
  int                          err_count = 0;
  int                          n_tests = 0;
  int                          lat;

  tkr_if bus_if ();

  tkr_device #(.LONG_PRESS_CYCLES(LONG_P), .STANDBY_CYCLES(STBY_P),
    .RESP_STBY_CYCLES(RESP_S), .RESP_NORM_CYCLES(RESP_N), .DRIFT_CYCLES(DRIFT_P)
  ) tkr_device_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .KEY_SENSE_I(KEY_SENSE_I),
    .KEY_VALUE_O(dev_value), .NORMAL_MODE_O(normal_mode), .BUS(bus_if.dev));

  tkr_host tkr_host_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .READ_REQ_I(READ_REQ_I),
    .READ_BUSY_O(read_busy), .READ_DONE_O(read_done), .READ_NACK_O(read_nack),
    .KEY_VALUE_O(host_value), .TOUCHED_O(touched), .BUS(bus_if.host));

  tkr_props tkr_props_inst (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .KEY_VALUE_O(dev_value),
    .scl(bus_if.scl), .sda(bus_if.sda), .int_n(bus_if.int_n), .dev_sda_o(bus_if.dev_sda_o),
    .dev_sda_oe(bus_if.dev_sda_oe), .dev_int_o(bus_if.dev_int_o),
    .dev_int_oe(bus_if.dev_int_oe));

  initial begin
    CORE_CLK_I = 1'b0;
    forever #12.5 CORE_CLK_I = ~CORE_CLK_I;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move a fixed 2 ns after the edge so the design never races them.
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #2;
  endtask

  function automatic logic [NUM_KEYS*SENSE_W-1:0] sense_of(input logic [9:0] mask);
    logic [NUM_KEYS*SENSE_W-1:0] s;
    for (int k = 0; k < NUM_KEYS; k++) begin
      s[k*SENSE_W +: SENSE_W] = mask[k] ? TOUCH : BASE;
    end
    return s;
  endfunction

  task automatic wait_value(input logic [15:0] exp, input int lim);
    lat = 0;
    while (dev_value !== exp && lat < lim) begin
      tick(1);
      lat++;
    end
    if (lat >= lim) begin
      err_count++;
      $display("[ERR] key value wait expected %h seen %h", exp, dev_value);
      complete_run();
    end
    check("key value", dev_value, exp);
  endtask

  task automatic press(input logic [9:0] mask, input int lo);
    KEY_SENSE_I = sense_of(mask);
    wait_value({6'h00, mask}, lo + 200);
    check("response time", {15'h0000, lat >= lo && lat <= lo + 5}, 16'h0001);
  endtask

  task automatic host_read(input logic [15:0] exp);
    int n;
    READ_REQ_I = 1'b1;
    tick(1);
    READ_REQ_I = 1'b0;
    check("read busy", {15'h0000, read_busy}, 16'h0001);
    n = 0;
    while (read_done !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    if (n >= 6000) begin
      err_count++;
      $display("[ERR] read done expected 1 seen %b", read_done);
      complete_run();
    end
    check("read nack", {15'h0000, read_nack}, 16'h0000);
    check("read idle", {15'h0000, read_busy}, 16'h0000);
    check("read value", host_value, exp);
    check("touched", {15'h0000, touched}, {15'h0000, exp != 16'h0000});
  endtask

  initial begin
    logic [9:0] m;
    KEY_SENSE_I = sense_of(10'h000);
    void'($urandom(31669));
    tick(16);
    RST_I = 1'b0;
    check("reset value", dev_value, KEY_VALUE_RST);
    check("reset line", {15'h0000, bus_if.int_n}, 16'h0001);
    host_read(16'h0000);
    for (int k = 0; k < NUM_KEYS; k++) begin
      // The opening read outlasts the idle limit, so the first key wakes from standby.
      press(10'h001 << k, (k == 0) ? RESP_S : RESP_N);
      check("line low", {15'h0000, bus_if.int_n}, 16'h0000);
      host_read({6'h00, 10'h001 << k});
      press(10'h000, RESP_N);
    end
    // Corner patterns first, then random ones; the first two change without a release.
    // Releases between the rest keep the hold time under the long-press limit.
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 10'h3FF : (i == 1) ? 10'h201 : 10'($urandom);
      if (m == 10'h000) begin
        m = 10'h155;
      end
      press(m, RESP_N);
      host_read({6'h00, m});
      if (i != 0 && i != 7) begin
        press(10'h000, RESP_N);
      end
    end
    press(10'h000, RESP_N);
    tick(STBY_P - 20);
    check("still normal", {15'h0000, normal_mode}, 16'h0001);
    tick(40);
    check("standby", {15'h0000, normal_mode}, 16'h0000);
    press(10'h004, RESP_S);
    check("woken", {15'h0000, normal_mode}, 16'h0001);
    wait_value(16'h0000, LONG_P + 100);
    check("hold time", {15'h0000, lat >= LONG_P - 5 && lat <= LONG_P + 5}, 16'h0001);
    check("line freed", {15'h0000, bus_if.int_n}, 16'h0001);
    tick(100);
    check("held key ignored", dev_value, KEY_VALUE_RST);
    host_read(16'h0000);
    // The reference now sits at the touched level; only drift brings it back.
    KEY_SENSE_I = sense_of(10'h000);
    tick(64 * DRIFT_P + 200);
    press(10'h004, RESP_S);
    press(10'h000, RESP_N);
    complete_run();
  end
endmodule
`default_nettype wire

/* File: logic/tkr_device.sv */
// Touch key status device: calibration, key reporting and bus read slave.
//
// Overview of operation
// - Capture reference at start, then track drift.
// - Ten second press: ignore key, recalibrate.
// - Timeout restores key value and line.
// - Several keys reported at once, own bits.
// - Status line low while any key touched.
// - Status line is open drain, pulled up.
// - Low key byte first, then high byte.
// - Key n sets bit n when touched.
// - After reset: value zero, line high.
// - Press wakes; four idle seconds enter standby.
// - Response 160 ms standby, 48 ms normal.
// - Bus runs up to 400 kbit/s.
// - Idle bus leaves both lines released high.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Data changes only while clock low.
// - Answer only the read byte 0xA7.
`timescale 1ns/1ps
`default_nettype none
module tkr_device #(
  parameter int unsigned LONG_PRESS_CYCLES = tkr_pkg::LONG_PRESS_CYC,
  parameter int unsigned STANDBY_CYCLES    = tkr_pkg::STANDBY_CYC,
  parameter int unsigned RESP_STBY_CYCLES  = tkr_pkg::RESP_STBY_CYC,
  parameter int unsigned RESP_NORM_CYCLES  = tkr_pkg::RESP_NORM_CYC,
  parameter int unsigned DRIFT_CYCLES      = tkr_pkg::DRIFT_CYC
) (
  input  wire logic                                          CORE_CLK_I,
  input  wire logic                                          RST_I,
  input  wire logic [tkr_pkg::NUM_KEYS*tkr_pkg::SENSE_W-1:0] KEY_SENSE_I,
  output logic      [tkr_pkg::KEY_VALUE_W-1:0]               KEY_VALUE_O,
  output logic                                               NORMAL_MODE_O,
  tkr_if.dev                                                 BUS
);
  import tkr_pkg::*;

  logic [SENSE_W-1:0]     ref_q [NUM_KEYS];
  logic                   ref_valid;
  logic [NUM_KEYS-1:0]    det;
  logic [NUM_KEYS-1:0]    ignore;
  logic [NUM_KEYS-1:0]    cand;
  logic [NUM_KEYS-1:0]    key_q;
  logic                   int_oe;
  logic                   mode_normal;
  logic [31:0]            stable_cnt;
  logic [31:0]            hold_cnt;
  logic [31:0]            idle_cnt;
  logic [31:0]            drift_cnt;
  logic [31:0]            resp_lim;
  logic                   long_fire;
  logic                   drift_tick;
  logic                   report;
  logic [2:0]             scl_ff;
  logic [2:0]             sda_ff;
  logic                   scl_f;
  logic                   sda_f;
  logic                   scl_s;
  logic                   sda_s;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_seen;
  logic                   stop_seen;
  tkr_dev_state_e         state;
  logic [3:0]             bit_cnt;
  logic [7:0]             rx_shift;
  logic [7:0]             tx_shift;
  logic [KEY_VALUE_W-1:0] tx_word;
  logic                   byte_sel;
  logic                   host_ack;
  logic                   sda_oe;

  function automatic logic [7:0] pick_byte(input logic [KEY_VALUE_W-1:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  assign long_fire  = (hold_cnt == LONG_PRESS_CYCLES - 1);
  assign drift_tick = (drift_cnt == DRIFT_CYCLES - 1);
  assign resp_lim   = mode_normal ? RESP_NORM_CYCLES : RESP_STBY_CYCLES;
  assign report     = (stable_cnt == resp_lim);

  genvar k;
  generate
    for (k = 0; k < NUM_KEYS; k++) begin : g_key
      logic [SENSE_W-1:0] sense;
      assign sense  = KEY_SENSE_I[k*SENSE_W +: SENSE_W];
      assign det[k] = ref_valid &&
                      ({1'b0, sense} > ({1'b0, ref_q[k]} + {1'b0, TOUCH_DELTA}));

      // Drift follows only while nothing is touched, so only the start capture or a long press ever learns a finger.
      always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
          ref_q[k] <= REF_RST;
        end else if (!ref_valid || long_fire) begin
          ref_q[k] <= sense;
        end else if (drift_tick && (det == '0) && (key_q == '0)) begin
          if (sense > ref_q[k]) begin
            ref_q[k] <= ref_q[k] + 8'h01;
          end else if (sense < ref_q[k]) begin
            ref_q[k] <= ref_q[k] - 8'h01;
          end
        end
      end

      always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
          ignore[k] <= 1'b0;
        end else if (long_fire && key_q[k]) begin
          ignore[k] <= 1'b1;
        end else if (!det[k]) begin
          ignore[k] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      ref_valid <= 1'b0;
    end else begin
      ref_valid <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || drift_tick) begin
      drift_cnt <= '0;
    end else begin
      drift_cnt <= drift_cnt + 32'd1;
    end
  end

  // A pattern must hold for the mode's response time before it is reported.
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || long_fire) begin
      cand       <= '0;
      stable_cnt <= '0;
    end else if ((det & ~ignore) != cand) begin
      cand       <= det & ~ignore;
      stable_cnt <= '0;
    end else if (stable_cnt < resp_lim) begin
      stable_cnt <= stable_cnt + 32'd1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || long_fire) begin
      key_q  <= KEY_VALUE_RST[NUM_KEYS-1:0];
      int_oe <= 1'b0;
    end else if (report) begin
      key_q  <= cand;
      int_oe <= |cand;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || (key_q == '0) || long_fire) begin
      hold_cnt <= '0;
    end else begin
      hold_cnt <= hold_cnt + 32'd1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I || (key_q != '0) || !mode_normal) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 32'd1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      mode_normal <= 1'b1;
    end else if (report && (cand != '0)) begin
      mode_normal <= 1'b1;
    end else if (idle_cnt == STANDBY_CYCLES - 1) begin
      mode_normal <= 1'b0;
    end
  end

  assign KEY_VALUE_O    = {{(KEY_VALUE_W-NUM_KEYS){1'b0}}, key_q};
  assign NORMAL_MODE_O  = mode_normal;
  assign BUS.dev_int_o  = 1'b0;
  assign BUS.dev_int_oe = int_oe;
  assign BUS.dev_sda_o  = 1'b0;
  assign BUS.dev_sda_oe = sda_oe;

  // Pin filter: a level is taken once the second and third stages agree.
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      scl_ff <= 3'h7;
      sda_ff <= 3'h7;
      scl_f  <= 1'b1;
      sda_f  <= 1'b1;
    end else begin
      scl_ff <= {scl_ff[1:0], BUS.scl};
      sda_ff <= {sda_ff[1:0], BUS.sda};
      scl_f  <= scl_s;
      sda_f  <= sda_s;
    end
  end

  assign scl_s      = (scl_ff[1] == scl_ff[2]) ? scl_ff[2] : scl_f;
  assign sda_s      = (sda_ff[1] == sda_ff[2]) ? sda_ff[2] : sda_f;
  assign scl_rise   = scl_s && !scl_f;
  assign scl_fall   = !scl_s && scl_f;
  assign start_seen = scl_s && scl_f && sda_f && !sda_s;
  assign stop_seen  = scl_s && scl_f && !sda_f && sda_s;

  // Slave engine: samples on clock rise, drives on clock fall.
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state    <= DS_IDLE;
      bit_cnt  <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      tx_word  <= KEY_VALUE_RST;
      byte_sel <= 1'b0;
      host_ack <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (start_seen) begin
      state   <= DS_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_seen) begin
      state  <= DS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        DS_ADDR: begin
          if (scl_rise) begin
            rx_shift <= {rx_shift[6:0], sda_s};
            bit_cnt  <= bit_cnt + 4'h1;
          end else if (scl_fall && (bit_cnt == 4'h8)) begin
            if (rx_shift == READ_BYTE) begin
              state    <= DS_ADDR_ACK;
              sda_oe   <= 1'b1;
              tx_word  <= KEY_VALUE_O;
              byte_sel <= 1'b0;
            end else begin
              state <= DS_IGNORE;
            end
          end
        end
        DS_ADDR_ACK: begin
          if (scl_fall) begin
            state    <= DS_SEND;
            bit_cnt  <= 4'h0;
            sda_oe   <= !tx_word[7];
            tx_shift <= 8'(pick_byte(tx_word, 1'b0) << 1);
          end
        end
        DS_SEND: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              state  <= DS_HOST_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe   <= !tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b0};
            end
          end
        end
        DS_HOST_ACK: begin
          if (scl_rise) begin
            host_ack <= !sda_s;
          end else if (scl_fall) begin
            if (host_ack && !byte_sel) begin
              state    <= DS_SEND;
              byte_sel <= 1'b1;
              bit_cnt  <= 4'h0;
              sda_oe   <= !tx_word[15];
              tx_shift <= 8'(pick_byte(tx_word, 1'b1) << 1);
            end else begin
              state <= DS_IGNORE;
            end
          end
        end
        DS_IDLE, DS_IGNORE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state  <= DS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: logic/tkr_host.sv */
// Bus host that reads the two key value bytes from the touch device.
`timescale 1ns/1ps
`default_nettype none
module tkr_host (
  input  wire logic                            CORE_CLK_I,
  input  wire logic                            RST_I,
  input  wire logic                            READ_REQ_I,
  output logic                                 READ_BUSY_O,
  output logic                                 READ_DONE_O,
  output logic                                 READ_NACK_O,
  output logic      [tkr_pkg::KEY_VALUE_W-1:0] KEY_VALUE_O,
  output logic                                 TOUCHED_O,
  tkr_if.host                                  BUS
);
  import tkr_pkg::*;

  localparam logic [7:0] PERIOD = SCL_LOW_CYC + SCL_HIGH_CYC;

  tkr_host_state_e  state;
  logic [7:0]       cnt;
  logic [3:0]       pos;
  logic [1:0]       byte_no;
  logic [15:0]      rx;
  logic             scl_oe;
  logic             sda_oe;
  logic [2:0]       sda_ff;
  logic [2:0]       int_ff;
  logic             sda_f;
  logic             int_f;

  // Zero address bits, then the ack on the first data byte, pull the line low.
  function automatic logic drive_low(input logic [1:0] b, input logic [3:0] p);
    logic [7:0] sh;
    sh = READ_BYTE << p;
    if (b == 2'd0) begin
      drive_low = (p < 4'h8) ? !sh[7] : 1'b0;
    end else begin
      drive_low = (b == 2'd1) && (p == 4'h8);
    end
  endfunction

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      sda_ff <= 3'h7;
      int_ff <= 3'h7;
      sda_f  <= 1'b1;
      int_f  <= 1'b1;
    end else begin
      sda_ff <= {sda_ff[1:0], BUS.sda};
      int_ff <= {int_ff[1:0], BUS.int_n};
      if (sda_ff[1] == sda_ff[2]) begin
        sda_f <= sda_ff[2];
      end
      if (int_ff[1] == int_ff[2]) begin
        int_f <= int_ff[2];
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      TOUCHED_O <= 1'b0;
    end else begin
      TOUCHED_O <= !int_f;
    end
  end

  assign BUS.host_scl_o  = 1'b0;
  assign BUS.host_sda_o  = 1'b0;
  assign BUS.host_scl_oe = scl_oe;
  assign BUS.host_sda_oe = sda_oe;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state       <= HS_IDLE;
      cnt         <= 8'h00;
      pos         <= 4'h0;
      byte_no     <= 2'd0;
      rx          <= 16'h0000;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      READ_BUSY_O <= 1'b0;
      READ_DONE_O <= 1'b0;
      READ_NACK_O <= 1'b0;
      KEY_VALUE_O <= KEY_VALUE_RST;
    end else begin
      READ_DONE_O <= 1'b0;
      cnt         <= cnt + 8'h01;
      case (state)
        HS_IDLE: begin
          cnt <= 8'h00;
          if (READ_REQ_I) begin
            state       <= HS_START;
            READ_BUSY_O <= 1'b1;
            READ_NACK_O <= 1'b0;
            pos         <= 4'h0;
            byte_no     <= 2'd0;
          end
        end
        HS_START: begin
          if (cnt == SCL_HIGH_CYC - 8'h01) begin
            sda_oe <= 1'b1;
            state  <= HS_HOLD;
            cnt    <= 8'h00;
          end
        end
        HS_HOLD: begin
          if (cnt == SCL_HIGH_CYC - 8'h01) begin
            scl_oe <= 1'b1;
            state  <= HS_BIT;
            cnt    <= 8'h00;
          end
        end
        HS_BIT: begin
          if (cnt == (SCL_LOW_CYC >> 1)) begin
            sda_oe <= drive_low(byte_no, pos);
          end
          if (cnt == SCL_LOW_CYC - 8'h01) begin
            scl_oe <= 1'b0;
          end
          if (cnt == SCL_LOW_CYC + (SCL_HIGH_CYC >> 1)) begin
            if (byte_no == 2'd0 && pos == 4'h8) begin
              READ_NACK_O <= sda_f;
            end else if (byte_no != 2'd0 && pos < 4'h8) begin
              rx <= {rx[14:0], sda_f};
            end
          end
          if (cnt == PERIOD - 8'h01) begin
            scl_oe <= 1'b1;
            cnt    <= 8'h00;
            pos    <= pos + 4'h1;
            if (pos == 4'h8) begin
              pos     <= 4'h0;
              byte_no <= byte_no + 2'd1;
              if (byte_no == 2'd2 || (byte_no == 2'd0 && READ_NACK_O)) begin
                state <= HS_STOP_LOW;
              end
            end
          end
        end
        HS_STOP_LOW: begin
          if (cnt == (SCL_LOW_CYC >> 1)) begin
            sda_oe <= 1'b1;
          end
          if (cnt == SCL_LOW_CYC - 8'h01) begin
            scl_oe <= 1'b0;
            state  <= HS_STOP_HIGH;
            cnt    <= 8'h00;
          end
        end
        HS_STOP_HIGH: begin
          if (cnt == SCL_HIGH_CYC - 8'h01) begin
            sda_oe <= 1'b0;
            state  <= HS_FREE;
            cnt    <= 8'h00;
          end
        end
        HS_FREE: begin
          if (cnt == BUS_FREE_CYC - 8'h01) begin
            state       <= HS_IDLE;
            READ_BUSY_O <= 1'b0;
            READ_DONE_O <= 1'b1;
            if (!READ_NACK_O) begin
              KEY_VALUE_O <= {rx[7:0], rx[15:8]};
            end
          end
        end
        default: begin
          state  <= HS_IDLE;
          scl_oe <= 1'b0;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: logic/tkr_if.sv */
// Open-drain wires between the key status device and its bus host.
`timescale 1ns/1ps
`default_nettype none
interface tkr_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_int_o;
  logic dev_int_oe;
  logic scl;
  logic sda;
  logic int_n;

  // Pull-ups make every undriven line read high.
  assign scl   = !(host_scl_oe && !host_scl_o);
  assign sda   = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  assign int_n = !(dev_int_oe && !dev_int_o);

  modport dev  (input scl, sda, output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe);
  modport host (input sda, int_n, output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface
`default_nettype wire

/* File: logic/tkr_pkg.sv */
// Shared constants and types for the touch key status reporter.
`default_nettype none
package tkr_pkg;
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CYC_PER_MS    = CLK_HZ / 1000;
  localparam int NUM_KEYS      = 10;
  localparam int SENSE_W       = 8;
  localparam int KEY_VALUE_W   = 16;
  localparam logic [KEY_VALUE_W-1:0] KEY_VALUE_RST = 16'h0000;
  localparam logic [SENSE_W-1:0]     TOUCH_DELTA   = 8'h10;
  localparam logic [SENSE_W-1:0]     REF_RST       = 8'h00;

  // Behaviour times in milliseconds; the cycle counts derive from them.
  localparam int LONG_PRESS_MS = 10_000;
  localparam int STANDBY_MS    = 4_000;
  localparam int RESP_STBY_MS  = 160;
  localparam int RESP_NORM_MS  = 48;
  localparam int DRIFT_MS      = 1;
  localparam int LONG_PRESS_CYC = LONG_PRESS_MS * CYC_PER_MS;
  localparam int STANDBY_CYC    = STANDBY_MS * CYC_PER_MS;
  localparam int RESP_STBY_CYC  = RESP_STBY_MS * CYC_PER_MS;
  localparam int RESP_NORM_CYC  = RESP_NORM_MS * CYC_PER_MS;
  localparam int DRIFT_CYC      = DRIFT_MS * CYC_PER_MS;

  // Serial bus: 1.5 us low plus 1.0 us high keeps the clock at 400 kHz.
  localparam int BUS_MAX_KBPS = 400;
  localparam int SCL_LOW_NS   = 1500;
  localparam int SCL_HIGH_NS  = 1000;
  localparam int BUS_FREE_NS  = 1300;
  localparam logic [7:0] SCL_LOW_CYC  = 8'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SCL_HIGH_CYC = 8'((SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] BUS_FREE_CYC = 8'((BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [6:0] DEV_ADDR     = 7'h53;
  localparam logic [7:0] READ_BYTE    = {DEV_ADDR, 1'b1};

  typedef enum logic [2:0] {
    DS_IDLE     = 3'b000,
    DS_ADDR     = 3'b001,
    DS_ADDR_ACK = 3'b010,
    DS_SEND     = 3'b011,
    DS_HOST_ACK = 3'b100,
    DS_IGNORE   = 3'b101
  } tkr_dev_state_e;

  typedef enum logic [2:0] {
    HS_IDLE      = 3'b000,
    HS_START     = 3'b001,
    HS_HOLD      = 3'b010,
    HS_BIT       = 3'b011,
    HS_STOP_LOW  = 3'b100,
    HS_STOP_HIGH = 3'b101,
    HS_FREE      = 3'b110
  } tkr_host_state_e;
endpackage
`default_nettype wire
